/* logic/stfc_top.sv */
// Two-channel temperature-driven fan output controller with an AXI4-Lite register slave.
//
// Function
// - Each channel loads target, tolerance, limits and step from its own registers.
// - Channel zero selects sensor by index 49h bits 2:0, one by 4Ah bits 7:5.
// - Inside target plus or minus tolerance the fan output value is held; a channel at zero restarts at its stop value.
// - Above target plus tolerance: output rises one step, target moves up by tolerance.
// - The step amount comes from the dedicated output step registers 68h and 6Ah.
// - Upward stepping stops at the channel maximum output value.
// - Below target minus tolerance: output falls one step, target moves down by tolerance.
// - Downward stepping stops at the channel stop value.
// - Staying cold, output decays to zero, or stays at stop value when enabled.
// - At the stop value the output is held for the programmed stop time.
// - Fan output value is an eight-bit duty, value over 255 of full scale.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "stfc_map.svh"
module stfc_top #(
	parameter int unsigned TICK_CYCLES = `STFC_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// AXI4-Lite write address channel
	input  wire logic [9:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data channel
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response channel
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address channel
	input  wire logic [9:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data channel
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Temperature readings, whole degrees
	input  wire stfc_pkg::stfc_byte_type system_temperature_input,
	input  wire stfc_pkg::stfc_byte_type processor_temperature_input,
	input  wire stfc_pkg::stfc_byte_type auxiliary_temperature_input,
	// Fan duty values to the fan drivers
	output logic [7:0]       fan_output_zero,
	output logic [7:0]       fan_output_one
);
	import stfc_pkg::*;

	// Settings registers.
	stfc_byte_type fan0_target_temperature_q;
	stfc_byte_type fan0_tolerance_q;
	stfc_byte_type fan0_stop_value_q;
	stfc_byte_type fan0_stop_time_q;
	stfc_byte_type step_down_interval_q;
	stfc_byte_type step_up_interval_q;
	stfc_byte_type keep_minimum_enables_q;
	stfc_byte_type sensor_select0_q;
	stfc_byte_type sensor_select1_q;
	stfc_byte_type fan1_tolerance_q;
	stfc_byte_type fan1_target_temperature_q;
	stfc_byte_type fan1_stop_value_q;
	stfc_byte_type fan1_stop_time_q;
	stfc_byte_type fan0_max_output_q;
	stfc_byte_type fan0_output_step_q;
	stfc_byte_type fan1_max_output_q;
	stfc_byte_type fan1_output_step_q;
	logic [1:0]    control_q;

	// Bus slave state.
	logic          aw_have_q;
	logic [7:0]    aw_idx_q;
	logic          w_have_q;
	logic [7:0]    w_data_q;
	logic          w_lane0_q;
	logic          bvalid_q;
	logic [1:0]    bresp_q;
	logic          rvalid_q;
	logic [31:0]   rdata_q;
	logic [1:0]    rresp_q;
	logic          wr_fire;
	logic          wr_en;
	logic          wr_mapped;
	logic          rd_mapped;
	logic [7:0]    rd_idx;
	stfc_byte_type rd_byte;

	// Loop state.
	logic [31:0]   tick_cnt_q;
	logic          tick_q;
	stfc_byte_type temp0;
	stfc_byte_type temp1;
	stfc_byte_type fan0_value;
	stfc_byte_type fan1_value;
	stfc_byte_type fan0_cur_target;
	stfc_byte_type fan1_cur_target;
	logic          fan0_at_stop;
	logic          fan1_at_stop;
	logic          load0;
	logic          load1;

	// Write channel: address and data are taken in either order, one write at a time.
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready  = !w_have_q && !bvalid_q;
	assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;
	assign wr_en         = wr_fire && w_lane0_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			aw_have_q <= 1'b0;
			aw_idx_q  <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			aw_idx_q  <= s_axi_awaddr[9:2];
		end else if (wr_fire) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			w_have_q  <= 1'b0;
			w_data_q  <= 8'h00;
			w_lane0_q <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q  <= 1'b1;
			w_data_q  <= s_axi_wdata[7:0];
			w_lane0_q <= s_axi_wstrb[0];
		end else if (wr_fire) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `STFC_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_mapped ? `STFC_RESP_OKAY : `STFC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Read-only indices accept a write with OKAY and ignore it.
	always_comb begin
		case (aw_idx_q)
			`STFC_IDX_FAN0_OUT, `STFC_IDX_FAN0_TARGET, `STFC_IDX_FAN0_TOL,
			`STFC_IDX_FAN0_STOP, `STFC_IDX_FAN0_STOP_TIME, `STFC_IDX_STEP_DOWN,
			`STFC_IDX_STEP_UP, `STFC_IDX_KEEP_MIN, `STFC_IDX_SENSOR_SEL0,
			`STFC_IDX_SENSOR_SEL1, `STFC_IDX_FAN1_OUT, `STFC_IDX_FAN1_TOL,
			`STFC_IDX_FAN1_TARGET, `STFC_IDX_FAN1_STOP, `STFC_IDX_FAN1_STOP_TIME,
			`STFC_IDX_FAN0_MAX, `STFC_IDX_FAN0_STEP, `STFC_IDX_FAN1_MAX,
			`STFC_IDX_FAN1_STEP, `STFC_IDX_CONTROL, `STFC_IDX_STATUS,
			`STFC_IDX_FAN0_CUR_TGT, `STFC_IDX_FAN1_CUR_TGT: wr_mapped = 1'b1;
			default: wr_mapped = 1'b0;
		endcase
	end

	// Settings registers take byte lane 0 of a write.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			fan0_target_temperature_q <= `STFC_RST_ZERO;
			fan0_tolerance_q          <= `STFC_RST_ZERO;
			fan0_stop_value_q         <= `STFC_RST_ZERO;
			fan0_stop_time_q          <= `STFC_RST_ZERO;
			step_down_interval_q      <= `STFC_RST_INTERVAL;
			step_up_interval_q        <= `STFC_RST_INTERVAL;
			keep_minimum_enables_q    <= `STFC_RST_ZERO;
			sensor_select0_q          <= `STFC_RST_ZERO;
			sensor_select1_q          <= `STFC_RST_ZERO;
			fan1_tolerance_q          <= `STFC_RST_ZERO;
			fan1_target_temperature_q <= `STFC_RST_ZERO;
			fan1_stop_value_q         <= `STFC_RST_ZERO;
			fan1_stop_time_q          <= `STFC_RST_ZERO;
			fan0_max_output_q         <= `STFC_RST_MAX;
			fan0_output_step_q        <= `STFC_RST_STEP;
			fan1_max_output_q         <= `STFC_RST_MAX;
			fan1_output_step_q        <= `STFC_RST_STEP;
			control_q                 <= 2'h0;
		end else if (wr_en) begin
			case (aw_idx_q)
				`STFC_IDX_FAN0_TARGET:    fan0_target_temperature_q <= w_data_q;
				`STFC_IDX_FAN0_TOL:       fan0_tolerance_q          <= w_data_q;
				`STFC_IDX_FAN0_STOP:      fan0_stop_value_q         <= w_data_q;
				`STFC_IDX_FAN0_STOP_TIME: fan0_stop_time_q          <= w_data_q;
				`STFC_IDX_STEP_DOWN:      step_down_interval_q      <= w_data_q;
				`STFC_IDX_STEP_UP:        step_up_interval_q        <= w_data_q;
				`STFC_IDX_KEEP_MIN:       keep_minimum_enables_q    <= w_data_q;
				`STFC_IDX_SENSOR_SEL0:    sensor_select0_q          <= w_data_q;
				`STFC_IDX_SENSOR_SEL1:    sensor_select1_q          <= w_data_q;
				`STFC_IDX_FAN1_TOL:       fan1_tolerance_q          <= w_data_q;
				`STFC_IDX_FAN1_TARGET:    fan1_target_temperature_q <= w_data_q;
				`STFC_IDX_FAN1_STOP:      fan1_stop_value_q         <= w_data_q;
				`STFC_IDX_FAN1_STOP_TIME: fan1_stop_time_q          <= w_data_q;
				`STFC_IDX_FAN0_MAX:       fan0_max_output_q         <= w_data_q;
				`STFC_IDX_FAN0_STEP:      fan0_output_step_q        <= w_data_q;
				`STFC_IDX_FAN1_MAX:       fan1_max_output_q         <= w_data_q;
				`STFC_IDX_FAN1_STEP:      fan1_output_step_q        <= w_data_q;
				`STFC_IDX_CONTROL:        control_q                 <= w_data_q[1:0];
				default: ;
			endcase
		end
	end

	// Output value registers live in the channels; a write overrides the loop for that cycle.
	assign load0 = wr_en && aw_idx_q == `STFC_IDX_FAN0_OUT;
	assign load1 = wr_en && aw_idx_q == `STFC_IDX_FAN1_OUT;

	// Read channel: data are registered, so the answer comes one edge after the address.
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign rd_idx        = s_axi_araddr[9:2];

	always_comb begin
		rd_mapped = 1'b1;
		case (rd_idx)
			`STFC_IDX_FAN0_OUT:       rd_byte = fan0_value;
			`STFC_IDX_FAN0_TARGET:    rd_byte = fan0_target_temperature_q;
			`STFC_IDX_FAN0_TOL:       rd_byte = fan0_tolerance_q;
			`STFC_IDX_FAN0_STOP:      rd_byte = fan0_stop_value_q;
			`STFC_IDX_FAN0_STOP_TIME: rd_byte = fan0_stop_time_q;
			`STFC_IDX_STEP_DOWN:      rd_byte = step_down_interval_q;
			`STFC_IDX_STEP_UP:        rd_byte = step_up_interval_q;
			`STFC_IDX_KEEP_MIN:       rd_byte = keep_minimum_enables_q;
			`STFC_IDX_SENSOR_SEL0:    rd_byte = sensor_select0_q;
			`STFC_IDX_SENSOR_SEL1:    rd_byte = sensor_select1_q;
			`STFC_IDX_FAN1_OUT:       rd_byte = fan1_value;
			`STFC_IDX_FAN1_TOL:       rd_byte = fan1_tolerance_q;
			`STFC_IDX_FAN1_TARGET:    rd_byte = fan1_target_temperature_q;
			`STFC_IDX_FAN1_STOP:      rd_byte = fan1_stop_value_q;
			`STFC_IDX_FAN1_STOP_TIME: rd_byte = fan1_stop_time_q;
			`STFC_IDX_FAN0_MAX:       rd_byte = fan0_max_output_q;
			`STFC_IDX_FAN0_STEP:      rd_byte = fan0_output_step_q;
			`STFC_IDX_FAN1_MAX:       rd_byte = fan1_max_output_q;
			`STFC_IDX_FAN1_STEP:      rd_byte = fan1_output_step_q;
			`STFC_IDX_CONTROL:        rd_byte = {6'h00, control_q};
			`STFC_IDX_STATUS:         rd_byte = {6'h00, fan1_at_stop, fan0_at_stop};
			`STFC_IDX_FAN0_CUR_TGT:   rd_byte = fan0_cur_target;
			`STFC_IDX_FAN1_CUR_TGT:   rd_byte = fan1_cur_target;
			default: begin
				rd_byte   = 8'h00;
				rd_mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `STFC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q  <= {24'h00_0000, rd_byte};
			rresp_q  <= rd_mapped ? `STFC_RESP_OKAY : `STFC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Interval tick shared by pacing and stop time.
	always_ff @(posedge clock) begin
		if (!rst_n || tick_cnt_q >= TICK_CYCLES - 32'd1) begin
			tick_cnt_q <= 32'h0000_0000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) tick_q <= 1'b0;
		else tick_q <= tick_cnt_q >= TICK_CYCLES - 32'd1;
	end

	// Sensor choice; codes outside the three sensors fall back to the system reading.
	function automatic stfc_byte_type pick_temp(input logic [2:0] sel);
		case (sel)
			STFC_SEL_PROCESSOR: pick_temp = processor_temperature_input;
			STFC_SEL_AUXILIARY: pick_temp = auxiliary_temperature_input;
			default:            pick_temp = system_temperature_input;
		endcase
	endfunction : pick_temp

	// A process, so a new reading is seen even while the sensor select stays put.
	always_comb begin
		temp0 = pick_temp(sensor_select0_q[`STFC_SEL0_HI:`STFC_SEL0_LO]);
		temp1 = pick_temp(sensor_select1_q[`STFC_SEL1_HI:`STFC_SEL1_LO]);
	end

	// Only two channels run the loop; in band each holds its value, or restarts at stop value from zero.
	stfc_channel u_channel0 (
		.clock         (clock),
		.rst_n         (rst_n),
		.enable        (control_q[`STFC_CTRL_EN0_BIT]),
		.tick          (tick_q),
		.keep_min      (keep_minimum_enables_q[`STFC_KEEP0_BIT]),
		.temperature   (temp0),
		.target        (fan0_target_temperature_q),
		.tolerance     (fan0_tolerance_q[`STFC_TOL0_HI:`STFC_TOL0_LO]),
		.step          (fan0_output_step_q),
		.max_out       (fan0_max_output_q),
		.stop_value    (fan0_stop_value_q),
		.stop_time     (fan0_stop_time_q),
		.up_interval   (step_up_interval_q),
		.down_interval (step_down_interval_q),
		.load          (load0),
		.load_value    (w_data_q),
		.out_value     (fan0_value),
		.cur_target    (fan0_cur_target),
		.at_stop       (fan0_at_stop)
	);

	stfc_channel u_channel1 (
		.clock         (clock),
		.rst_n         (rst_n),
		.enable        (control_q[`STFC_CTRL_EN1_BIT]),
		.tick          (tick_q),
		.keep_min      (keep_minimum_enables_q[`STFC_KEEP1_BIT]),
		.temperature   (temp1),
		.target        (fan1_target_temperature_q),
		.tolerance     (fan1_tolerance_q[`STFC_TOL1_HI:`STFC_TOL1_LO]),
		.step          (fan1_output_step_q),
		.max_out       (fan1_max_output_q),
		.stop_value    (fan1_stop_value_q),
		.stop_time     (fan1_stop_time_q),
		.up_interval   (step_up_interval_q),
		.down_interval (step_down_interval_q),
		.load          (load1),
		.load_value    (w_data_q),
		.out_value     (fan1_value),
		.cur_target    (fan1_cur_target),
		.at_stop       (fan1_at_stop)
	);

	assign fan_output_zero = fan0_value;
	assign fan_output_one  = fan1_value;
endmodule : stfc_top
`default_nettype wire

/* logic/stfc_map.svh */
// Register indices, field positions, reset values and timing counts of the fan controller.
`ifndef STFC_MAP_SVH
`define STFC_MAP_SVH

`define STFC_IDX_FAN0_OUT       8'h03
`define STFC_IDX_FAN0_TARGET    8'h06
`define STFC_IDX_FAN0_TOL       8'h07
`define STFC_IDX_FAN0_STOP      8'h09
`define STFC_IDX_FAN0_STOP_TIME 8'h0d
`define STFC_IDX_STEP_DOWN      8'h0e
`define STFC_IDX_STEP_UP        8'h0f
`define STFC_IDX_KEEP_MIN       8'h12
`define STFC_IDX_SENSOR_SEL0    8'h49
`define STFC_IDX_SENSOR_SEL1    8'h4a
`define STFC_IDX_FAN1_OUT       8'h61
`define STFC_IDX_FAN1_TOL       8'h62
`define STFC_IDX_FAN1_TARGET    8'h63
`define STFC_IDX_FAN1_STOP      8'h64
`define STFC_IDX_FAN1_STOP_TIME 8'h66
`define STFC_IDX_FAN0_MAX       8'h67
`define STFC_IDX_FAN0_STEP      8'h68
`define STFC_IDX_FAN1_MAX       8'h69
`define STFC_IDX_FAN1_STEP      8'h6a
`define STFC_IDX_CONTROL        8'h70
`define STFC_IDX_STATUS         8'h71
`define STFC_IDX_FAN0_CUR_TGT   8'h72
`define STFC_IDX_FAN1_CUR_TGT   8'h73

`define STFC_TOL0_HI      7
`define STFC_TOL0_LO      4
`define STFC_TOL1_HI      3
`define STFC_TOL1_LO      0
`define STFC_SEL0_HI      2
`define STFC_SEL0_LO      0
`define STFC_SEL1_HI      7
`define STFC_SEL1_LO      5
`define STFC_KEEP0_BIT    4
`define STFC_KEEP1_BIT    6
`define STFC_CTRL_EN0_BIT 0
`define STFC_CTRL_EN1_BIT 1

`define STFC_RST_OUTPUT   8'hff
`define STFC_RST_MAX      8'hff
`define STFC_RST_ZERO     8'h00
`define STFC_RST_STEP     8'h01
`define STFC_RST_INTERVAL 8'h01

`define STFC_CLOCK_HZ     25000000
`define STFC_TICK_MS      100
`define STFC_TICK_CYCLES  (`STFC_CLOCK_HZ / 1000 * `STFC_TICK_MS)

`define STFC_RESP_OKAY    2'b00
`define STFC_RESP_SLVERR  2'b10

`endif

/* logic/stfc_pkg.sv */
// Types shared by the fan controller modules.
package stfc_pkg;
	typedef enum logic [1:0] {
		STFC_IDLE = 2'b00,
		STFC_RUN  = 2'b01,
		STFC_HOLD = 2'b11,
		STFC_ZERO = 2'b10
	} stfc_state_type;
	typedef enum logic [2:0] {
		STFC_SEL_SYSTEM    = 3'h0,
		STFC_SEL_PROCESSOR = 3'h1,
		STFC_SEL_AUXILIARY = 3'h2
	} stfc_sensor_type;
	typedef logic [7:0] stfc_byte_type;
endpackage : stfc_pkg

/* logic/stfc_channel.sv */
// One closed-loop fan channel: band check, paced stepping, clamps and stop hold.
`timescale 1ns/1ps
`default_nettype none
`include "stfc_map.svh"
module stfc_channel (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst_n,
	// Control and pacing
	input  wire logic              enable,
	input  wire logic              tick,
	input  wire logic              keep_min,
	// Settings
	input  wire stfc_pkg::stfc_byte_type temperature,
	input  wire stfc_pkg::stfc_byte_type target,
	input  wire logic [3:0]        tolerance,
	input  wire stfc_pkg::stfc_byte_type step,
	input  wire stfc_pkg::stfc_byte_type max_out,
	input  wire stfc_pkg::stfc_byte_type stop_value,
	input  wire stfc_pkg::stfc_byte_type stop_time,
	input  wire stfc_pkg::stfc_byte_type up_interval,
	input  wire stfc_pkg::stfc_byte_type down_interval,
	// Software write of the output value
	input  wire logic              load,
	input  wire stfc_pkg::stfc_byte_type load_value,
	// State
	output logic [7:0]             out_value,
	output logic [7:0]             cur_target,
	output logic                   at_stop
);
	import stfc_pkg::*;
	stfc_state_type state_q;
	logic [7:0] out_q, tgt_q, pace_q, hold_q;
	logic [8:0] high_end, up_sum;
	logic       hot, cold, step_up, step_down;

	assign high_end  = {1'b0, tgt_q} + {5'h00, tolerance};
	assign hot       = {1'b0, temperature} > high_end;
	assign cold      = ({1'b0, temperature} + {5'h00, tolerance}) < {1'b0, tgt_q};
	assign up_sum    = {1'b0, out_q} + {1'b0, step};
	// Pacing counts whole ticks, so a change may land up to one tick late after a write.
	assign step_up   = !load && enable && state_q == STFC_RUN && hot && tick
		&& pace_q >= up_interval && out_q < max_out;
	assign step_down = !load && enable && state_q == STFC_RUN && !hot && cold && tick
		&& pace_q >= down_interval;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_q <= STFC_IDLE;
			out_q   <= `STFC_RST_OUTPUT;
			tgt_q   <= `STFC_RST_ZERO;
		end else if (load) begin
			out_q <= load_value;
		end else begin
			case (state_q)
				STFC_IDLE: if (enable) begin
					state_q <= STFC_RUN;
					tgt_q   <= target;
				end
				STFC_RUN: if (!enable) begin
					state_q <= STFC_IDLE;
				end else if (step_up) begin
					out_q <= (up_sum > {1'b0, max_out}) ? max_out : up_sum[7:0];
					tgt_q <= high_end[8] ? 8'hff : high_end[7:0];
				end else if (step_down && out_q > stop_value) begin
					out_q <= ({1'b0, out_q} < {1'b0, stop_value} + {1'b0, step}) ?
						stop_value : out_q - step;
					tgt_q <= tgt_q - {4'h0, tolerance};
				end else if (step_down) begin
					state_q <= STFC_HOLD;
				end
				STFC_HOLD: if (!enable) begin
					state_q <= STFC_IDLE;
				end else if (!cold) begin
					state_q <= STFC_RUN;
				end else if (tick && hold_q >= stop_time) begin
					state_q <= keep_min ? STFC_RUN : STFC_ZERO;
					if (!keep_min) out_q <= `STFC_RST_ZERO;
				end
				STFC_ZERO: if (!enable) begin
					state_q <= STFC_IDLE;
				end else if (!cold) begin
					state_q <= STFC_RUN;
					out_q   <= stop_value;
				end
				default: state_q <= STFC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n || step_up || step_down) pace_q <= `STFC_RST_ZERO;
		else if (tick && pace_q != 8'hff) pace_q <= pace_q + 8'h01;
	end

	always_ff @(posedge clock) begin
		if (!rst_n || state_q != STFC_HOLD) hold_q <= `STFC_RST_ZERO;
		else if (tick && hold_q != 8'hff) hold_q <= hold_q + 8'h01;
	end

	assign out_value  = out_q;
	assign cur_target = tgt_q;
	assign at_stop    = state_q == STFC_HOLD;
endmodule : stfc_channel
`default_nettype wire

/* verification/stfc_props.sv */
// Port-level protocol and reset checks for the fan controller.
`timescale 1ns/1ps
`default_nettype none
module stfc_props #(
	parameter int unsigned TICK_CYCLES = 4
) (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Fan duty values
	input wire logic [7:0]  fan_output_zero,
	input wire logic [7:0]  fan_output_one
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer missing");
	a_rdata_stand: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
	a_bresp_stand: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response moved");
	a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken early");
	a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken early");
	a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	a_reset_full: assert property ($rose(rst_n) |-> fan_output_zero == 8'hff
		&& fan_output_one == 8'hff) else $error("fan not full after reset");
endmodule : stfc_props
bind stfc_top stfc_props #(.TICK_CYCLES(TICK_CYCLES)) stfc_props_i (
	.clock(clock), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .fan_output_zero(fan_output_zero),
	.fan_output_one(fan_output_one));
`default_nettype wire

/* verification/stfc_sense_model.sv */
// Far side model: sensor readings fed to the controller and the duty the fans receive.
`timescale 1ns/1ps
`default_nettype none
module stfc_sense_model (
	// Clock
	input  wire logic                    clock,
	// Duty values seen by the fan drivers
	input  wire stfc_pkg::stfc_byte_type fan_zero,
	input  wire stfc_pkg::stfc_byte_type fan_one,
	// Sensor readings, whole degrees
	output var stfc_pkg::stfc_byte_type  sys_t,
	output var stfc_pkg::stfc_byte_type  cpu_t,
	output var stfc_pkg::stfc_byte_type  aux_t
);
	import stfc_pkg::*;
	initial begin
		sys_t = 8'h00;
		cpu_t = 8'h00;
		aux_t = 8'h00;
	end
	// Readings change only just after an edge, as a real converter updates its result.
	task automatic set_t(input int s, input stfc_byte_type v);
		if (s == 0) sys_t <= v;
		else if (s == 1) cpu_t <= v;
		else aux_t <= v;
	endtask : set_t
endmodule : stfc_sense_model
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the two-channel fan controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import stfc_pkg::*;
	logic          clock = 0;
	logic          rst_n = 0;
	logic [9:0]    aw = '0;
	logic [9:0]    ar = '0;
	logic [31:0]   wd = '0;
	logic [31:0]   rdata;
	logic          awv = 0, wv = 0, arv = 0, bready = 0, rready = 0;
	logic          awr, wrdy, arr, bv, rv;
	logic [1:0]    bresp, rresp;
	stfc_byte_type ts, tc, ta, f0, f1;
	int            errors = 0;
	int            check_count = 0;
	logic [7:0]    ri [10] = '{8'h03, 8'h61, 8'h67, 8'h69, 8'h68, 8'h6a, 8'h0e, 8'h0f, 8'h06, 8'h70};
	logic [7:0]    re [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
	logic [7:0]    ci [15] = '{8'h06, 8'h07, 8'h68, 8'h67, 8'h09, 8'h0d, 8'h49, 8'h03,
		8'h63, 8'h62, 8'h6a, 8'h64, 8'h66, 8'h12, 8'h4a};
	logic [7:0]    cd [15] = '{8'h28, 8'h20, 8'h10, 8'h80, 8'h20, 8'h03, 8'h01, 8'h40,
		8'h0a, 8'h01, 8'h40, 8'h30, 8'h01, 8'h40, 8'h40};
	stfc_top #(.TICK_CYCLES(4)) stfc_top_i (
		.clock(clock), .rst_n(rst_n), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
		.s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
		.s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
		.system_temperature_input(ts), .processor_temperature_input(tc),
		.auxiliary_temperature_input(ta), .fan_output_zero(f0), .fan_output_one(f1));
	stfc_sense_model stfc_sense_model_i (.clock(clock), .fan_zero(f0), .fan_one(f1),
		.sys_t(ts), .cpu_t(tc), .aux_t(ta));
	always #20 clock = ~clock;
	task automatic close_out();
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : close_out
	task automatic tmo(input bit hit);
		if (hit) begin
			errors++;
			$display("CHECK FAILED t=%0t wait ran out", $time);
			close_out();
		end
	endtask : tmo
	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t value %h expected %h", $time, g, e);
		end
	endtask : cmp8
	task automatic cmp2(input logic [1:0] g, input logic [1:0] e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t response %b expected %b", $time, g, e);
		end
	endtask : cmp2
	// Response ready goes up with the request and stays until the answer is seen.
	task automatic wr(input logic [7:0] ix, input logic [7:0] d, input logic [1:0] er);
		int n;
		n = 0;
		aw <= {ix, 2'b00};
		wd <= {24'h00_0000, d};
		awv <= 1;
		wv <= 1;
		bready <= 1;
		do begin
			@(posedge clock);
			n++;
			if (awr) awv <= 0;
			if (wrdy) wv <= 0;
		end while (bv !== 1'b1 && n < 200);
		tmo(n >= 200);
		cmp2(bresp, er);
		bready <= 0;
		@(posedge clock);
	endtask : wr
	task automatic rd(input logic [7:0] ix, input logic [7:0] e, input logic [1:0] er);
		int n;
		n = 0;
		ar <= {ix, 2'b00};
		arv <= 1;
		rready <= 1;
		do begin
			@(posedge clock);
			n++;
			if (arr) arv <= 0;
		end while (rv !== 1'b1 && n < 200);
		tmo(n >= 200);
		cmp8(rdata[7:0], e);
		cmp2(rresp, er);
		rready <= 0;
		@(posedge clock);
	endtask : rd
	task automatic waitv(input bit ch, input logic [7:0] v, input int lim);
		int n;
		n = 0;
		while ((ch ? f1 : f0) !== v && n <= lim) begin
			@(posedge clock);
			n++;
		end
		tmo(n > lim);
		cmp8(ch ? f1 : f0, v);
	endtask : waitv
	initial begin
		repeat (2) @(posedge clock);
		rst_n <= 1;
		@(posedge clock);
		for (int i = 0; i < 10; i++) rd(ri[i], re[i], 2'b00);
		rd(8'h20, 8'h00, 2'b10);
		wr(8'h20, 8'h55, 2'b10);
		for (int i = 0; i < 15; i++) wr(ci[i], cd[i], 2'b00);
		stfc_sense_model_i.set_t(0, 8'h64);
		stfc_sense_model_i.set_t(1, 8'h29);
		stfc_sense_model_i.set_t(2, 8'h64);
		wr(8'h70, 8'h01, 2'b00);
		repeat (20) @(posedge clock);
		cmp8(f0, 8'h40);
		rd(8'h72, 8'h28, 2'b00);
		stfc_sense_model_i.set_t(1, 8'h2b);
		waitv(0, 8'h50, 40);
		repeat (20) @(posedge clock);
		cmp8(f0, 8'h50);
		rd(8'h72, 8'h2a, 2'b00);
		wr(8'h0f, 8'h03, 2'b00);
		stfc_sense_model_i.set_t(1, 8'h64);
		waitv(0, 8'h60, 60);
		repeat (8) @(posedge clock);
		cmp8(f0, 8'h60);
		waitv(0, 8'h80, 100);
		repeat (40) @(posedge clock);
		cmp8(f0, 8'h80);
		stfc_sense_model_i.set_t(1, 8'h00);
		waitv(0, 8'h20, 200);
		repeat (8) @(posedge clock);
		cmp8(f0, 8'h20);
		waitv(0, 8'h00, 100);
		rd(8'h03, 8'h00, 2'b00);
		stfc_sense_model_i.set_t(2, 8'h00);
		wr(8'h70, 8'h03, 2'b00);
		waitv(1, 8'hbf, 40);
		waitv(1, 8'h30, 100);
		repeat (60) @(posedge clock);
		cmp8(f1, 8'h30);
		close_out();
	end
endmodule : tb_top
`default_nettype wire
